// file: rtl/acsq_defines.svh
// Register map, reset values, field codes and masks for the converter sequencer
//
// Notes on behaviour
// - Control field picks full, mid or low power; the core runs at that level.
// - Control field picks continuous, single, standby, power-down or calibration mode.
// - Control holds clock source and internal reference enable, both driven to core.
// - Control bits enable status-appended reads and continuous result read.
// - Control is a 16-bit read/write register resetting to zero.
// - Diagnostic flags: 24-bit read-only, reset zero, one flag per diagnostic.
// - Diagnostic enables: 24-bit read/write, reset 0x000040, plus count and test controls.
// - Clock pulse counter: 8-bit read-only, resets to zero.
// - Counter counts master clock pulses while clock counting is enabled.
// - Enabled diagnostics set own flag; enabled flags ORed into one status error bit.
// - Write-ignore diagnostic on by default; flags writes refused while blocked.
// - A channel joins the sequence only while its top bit is set.
// - Sequencer steps enabled channels upward in continuous mode, then wraps to lowest, endlessly.
// - Sixteen 16-bit channel registers, reset 0x8001: enable, setup, two input selects.
// - Any of sixteen input pins may be the positive or negative input.
// - Eight setups; each channel uses the setup its setup field names.
// - Finished calibration writes coefficients into the active channel's setup.
// - Gain above one forces both input buffers on.
// - At gain one each input buffer follows its own configuration bit.
// - Eight 16-bit setup registers, reset 0x0860, holding buffers, reference, gain.
`ifndef ACSQ_DEFINES_SVH
`define ACSQ_DEFINES_SVH

`define ACSQ_OFF_CTRL 6'h01
`define ACSQ_OFF_FLAGS 6'h06
`define ACSQ_OFF_ENABLES 6'h07
`define ACSQ_OFF_COUNT 6'h08
`define ACSQ_OFF_CH_FIRST 6'h09
`define ACSQ_OFF_CH_LAST 6'h18
`define ACSQ_OFF_CFG_FIRST 6'h19
`define ACSQ_OFF_CFG_LAST 6'h20

`define ACSQ_RST_CTRL 16'h0000
`define ACSQ_RST_FLAGS 24'h000000
`define ACSQ_RST_ENABLES 24'h000040
`define ACSQ_RST_COUNT 8'h00
`define ACSQ_RST_CH 16'h8001
`define ACSQ_RST_CFG 16'h0860

`define ACSQ_MASK_CTRL 16'h1fff
`define ACSQ_MASK_ENABLES 24'h7fffff
`define ACSQ_MASK_CH 16'hf3ff
`define ACSQ_MASK_CFG 16'h0fff
`define ACSQ_MASK_FLAGS 24'h0ffaff

`define ACSQ_BIT_IGNORE 6
`define ACSQ_BIT_CAP_FLAG 19
`define ACSQ_BIT_CAP_CHK_LO 19
`define ACSQ_BIT_CAP_CHK_HI 20
`define ACSQ_BIT_COUNT_ON 22

`define ACSQ_MODE_CONT 4'h0
`define ACSQ_MODE_SINGLE 4'h1
`define ACSQ_MODE_CAL_FIRST 4'h4
`define ACSQ_MODE_CAL_LAST 4'h8

`endif

// file: rtl/acsq_pkg.sv
// Types shared by the converter configuration and channel sequencer
package acsq_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [23:0] wdata;
  } acsq_req_type;

  typedef struct packed {
    logic [2:0] rsvd;
    logic ready_output_delay;
    logic continuous_result_read;
    logic data_with_status;
    logic cs_enable;
    logic ref_enable;
    logic [1:0] power_mode;
    logic [3:0] op_mode;
    logic [1:0] clock_select;
  } acsq_ctrl_type;

  typedef struct packed {
    logic enable;
    logic [2:0] setup;
    logic [1:0] rsvd;
    logic [4:0] positive_input_select;
    logic [4:0] negative_input_select;
  } acsq_chan_type;

  typedef struct packed {
    logic [3:0] rsvd;
    logic bipolar;
    logic [1:0] burnout;
    logic positive_reference_buffer_on;
    logic negative_reference_buffer_on;
    logic positive_input_buffer_on;
    logic negative_input_buffer_on;
    logic [1:0] ref_select;
    logic [2:0] gain_select;
  } acsq_setup_type;

  typedef struct packed {
    logic [3:0] channel;
    logic [2:0] setup;
    logic [4:0] positive_input_select;
    logic [4:0] negative_input_select;
    logic [2:0] gain_select;
    logic positive_input_buffer_on;
    logic negative_input_buffer_on;
    logic positive_reference_buffer_on;
    logic negative_reference_buffer_on;
    logic [1:0] ref_select;
    logic bipolar;
    logic [1:0] burnout;
  } acsq_route_type;

endpackage

// file: rtl/acsq_regbank.sv
// Configuration register bank and automatic channel sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acsq_defines.svh"

module acsq_regbank #(
  parameter int NUM_CH = 16,
  parameter int NUM_SETUP = 8
) (
  input wire logic core_clk, // Core clock, 10 MHz
  input wire logic rst, // Async reset, active high
  input wire acsq_pkg::acsq_req_type req, // Register access from serial decoder
  input wire logic write_block, // Core busy: writes not accepted
  input wire logic [23:0] diag_event, // Diagnostic fault pulses
  input wire logic mclk_tick, // One pulse per master clock
  input wire logic conv_done, // Conversion finished pulse
  input wire logic cal_done, // Calibration finished pulse
  output var logic [23:0] rdata, // Read data
  output var logic rdata_valid, // Read data strobe
  output var logic status_err, // Summary error bit
  output var acsq_pkg::acsq_ctrl_type ctrl, // Control register fields
  output var acsq_pkg::acsq_route_type route, // Active channel routing
  output var logic seq_empty, // No channel enabled
  output var logic cal_write, // Coefficient write pulse
  output var logic [2:0] cal_setup // Setup receiving coefficients
);

  // ==========================================================
  // Elaboration checks
  // Offsets span exactly sixteen channels and eight setups
  if (NUM_CH != 16 || NUM_SETUP != 8)
  begin : g_bad_size
    $error("acsq_regbank: only 16 channels and 8 setups fit the map");
  end

  // ==========================================================
  // Storage
  acsq_pkg::acsq_ctrl_type ctrl_reg;
  logic [23:0] flags_reg;
  logic [23:0] flags_next;
  logic [23:0] enables_reg;
  logic [7:0] count_reg;
  logic [15:0] chan_reg [NUM_CH];
  logic [15:0] cfg_reg [NUM_SETUP];
  logic [3:0] active_reg;
  logic [3:0] active_next;
  logic [23:0] rdata_reg;
  logic [23:0] rd_mux;
  logic rdata_valid_reg;
  logic status_err_reg;
  acsq_pkg::acsq_route_type route_reg;
  acsq_pkg::acsq_route_type route_next;
  logic seq_empty_reg;
  logic cal_write_reg;
  logic [2:0] cal_setup_reg;

  // ==========================================================
  // Address decode
  wire logic [5:0] addr = req.addr;
  wire logic hit_ctrl = addr == `ACSQ_OFF_CTRL;
  wire logic hit_flags = addr == `ACSQ_OFF_FLAGS;
  wire logic hit_en = addr == `ACSQ_OFF_ENABLES;
  wire logic hit_cnt = addr == `ACSQ_OFF_COUNT;
  wire logic hit_ch = addr >= `ACSQ_OFF_CH_FIRST && addr <= `ACSQ_OFF_CH_LAST;
  wire logic hit_cfg = addr >= `ACSQ_OFF_CFG_FIRST && addr <= `ACSQ_OFF_CFG_LAST;
  wire logic [5:0] ch_off = addr - `ACSQ_OFF_CH_FIRST;
  wire logic [5:0] cfg_off = addr - `ACSQ_OFF_CFG_FIRST;
  wire logic [3:0] ch_idx = ch_off[3:0];
  wire logic [2:0] cfg_idx = cfg_off[2:0];

  // Writes are refused while the core blocks them and the check is on
  wire logic ignore_on = enables_reg[`ACSQ_BIT_IGNORE];
  wire logic wr_ok = req.wr && !(ignore_on && write_block);

  // ==========================================================
  // Control register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctrl_reg <= `ACSQ_RST_CTRL;
    else if (wr_ok && hit_ctrl)
      ctrl_reg <= req.wdata[15:0] & `ACSQ_MASK_CTRL;
  end

  // ==========================================================
  // Diagnostic enables
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      enables_reg <= `ACSQ_RST_ENABLES;
    else if (wr_ok && hit_en)
      enables_reg <= req.wdata & `ACSQ_MASK_ENABLES;
  end

  // ==========================================================
  // Diagnostic flags
  // Per-flag gate; the capacitor check uses a two-bit enable field
  logic [23:0] gate;
  logic [23:0] fault;
  for (genvar b = 0; b < 24; b++)
  begin : g_gate
    localparam logic [23:0] FLAG_MASK = `ACSQ_MASK_FLAGS;
    if (b == `ACSQ_BIT_CAP_FLAG)
    begin : g_cap
      assign gate[b] = |enables_reg[`ACSQ_BIT_CAP_CHK_HI:`ACSQ_BIT_CAP_CHK_LO];
    end
    else
    begin : g_plain
      assign gate[b] = FLAG_MASK[b] & enables_reg[b];
    end
    if (b == `ACSQ_BIT_IGNORE)
    begin : g_ign
      assign fault[b] = diag_event[b] | (req.wr & write_block);
    end
    else
    begin : g_evt
      assign fault[b] = diag_event[b];
    end
  end

  // Read of the flags clears them; a fault in the same cycle wins
  wire logic flags_read = req.rd && hit_flags;
  always_comb
  begin
    flags_next = flags_reg;
    if (flags_read)
      flags_next = '0;
    flags_next = (flags_next | (fault & gate)) & gate;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flags_reg <= `ACSQ_RST_FLAGS;
    else
      flags_reg <= flags_next;
  end

  // Summary bit follows the flags held for the host to read
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status_err_reg <= 1'b0;
    else
      status_err_reg <= |flags_next;
  end

  // ==========================================================
  // Master clock pulse counter
  // Wraps at 8 bits; software times a window and reads the change
  wire logic count_on = enables_reg[`ACSQ_BIT_COUNT_ON];
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_reg <= `ACSQ_RST_COUNT;
    else if (count_on && mclk_tick)
      count_reg <= count_reg + 8'h01;
  end

  // ==========================================================
  // Channel and setup registers
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_chan
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        chan_reg[c] <= `ACSQ_RST_CH;
      else if (wr_ok && hit_ch && ch_idx == 4'(c))
        chan_reg[c] <= req.wdata[15:0] & `ACSQ_MASK_CH;
    end
  end

  for (genvar s = 0; s < NUM_SETUP; s++)
  begin : g_setup
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        cfg_reg[s] <= `ACSQ_RST_CFG;
      else if (wr_ok && hit_cfg && cfg_idx == 3'(s))
        cfg_reg[s] <= req.wdata[15:0] & `ACSQ_MASK_CFG;
    end
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    rd_mux = 24'h000000;
    if (hit_ctrl)
      rd_mux = {8'h00, ctrl_reg};
    else if (hit_flags)
      rd_mux = flags_reg;
    else if (hit_en)
      rd_mux = enables_reg;
    else if (hit_cnt)
      rd_mux = {16'h0000, count_reg};
    else if (hit_ch)
      rd_mux = {8'h00, chan_reg[ch_idx]};
    else if (hit_cfg)
      rd_mux = {8'h00, cfg_reg[cfg_idx]};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 24'h000000;
      rdata_valid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= req.rd ? rd_mux : rdata_reg;
      rdata_valid_reg <= req.rd;
    end
  end

  // ==========================================================
  // Sequencer
  logic [NUM_CH-1:0] ch_en;
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_en
    assign ch_en[c] = chan_reg[c][15];
  end

  // Next enabled channel above cur, wrapping; cur itself last
  function automatic logic [3:0] next_enabled(input logic [3:0] cur,
                                              input logic [15:0] en);
    logic [3:0] pick;
    logic found;
    logic [3:0] idx;
    pick = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      idx = cur + i[3:0];
      if (!found && en[idx])
      begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  wire logic op_cont = ctrl_reg.op_mode == `ACSQ_MODE_CONT;
  wire logic op_cal = ctrl_reg.op_mode >= `ACSQ_MODE_CAL_FIRST &&
                      ctrl_reg.op_mode <= `ACSQ_MODE_CAL_LAST;
  wire logic [3:0] seq_step = next_enabled(active_reg, ch_en);

  // Step on each finished conversion in continuous mode; leave a channel once disabled
  always_comb
  begin
    active_next = active_reg;
    if (!ch_en[active_reg])
      active_next = seq_step;
    else if (op_cont && conv_done)
      active_next = seq_step;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      active_reg <= 4'h0;
    else
      active_reg <= active_next;
  end

  // ==========================================================
  // Routing of the active channel through its setup
  acsq_pkg::acsq_chan_type cur_ch;
  acsq_pkg::acsq_setup_type cur_cfg;
  assign cur_ch = chan_reg[active_next];
  assign cur_cfg = cfg_reg[cur_ch.setup];
  wire logic gain_up = cur_cfg.gain_select != 3'h0;

  always_comb
  begin
    route_next.channel = active_next;
    route_next.setup = cur_ch.setup;
    route_next.positive_input_select = cur_ch.positive_input_select;
    route_next.negative_input_select = cur_ch.negative_input_select;
    route_next.gain_select = cur_cfg.gain_select;
    // Rail-to-rail gain stage needs the buffers behind it
    route_next.positive_input_buffer_on =
      gain_up | cur_cfg.positive_input_buffer_on;
    route_next.negative_input_buffer_on =
      gain_up | cur_cfg.negative_input_buffer_on;
    route_next.positive_reference_buffer_on = cur_cfg.positive_reference_buffer_on;
    route_next.negative_reference_buffer_on = cur_cfg.negative_reference_buffer_on;
    route_next.ref_select = cur_cfg.ref_select;
    route_next.bipolar = cur_cfg.bipolar;
    route_next.burnout = cur_cfg.burnout;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      route_reg <= '0;
      seq_empty_reg <= 1'b0;
    end
    else
    begin
      route_reg <= route_next;
      seq_empty_reg <= ~|ch_en;
    end
  end

  // ==========================================================
  // Calibration result write-back
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cal_write_reg <= 1'b0;
      cal_setup_reg <= 3'h0;
    end
    else
    begin
      cal_write_reg <= cal_done && op_cal;
      cal_setup_reg <= cal_done && op_cal ? route_reg.setup : cal_setup_reg;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = rdata_reg;
  assign rdata_valid = rdata_valid_reg;
  assign status_err = status_err_reg;
  assign ctrl = ctrl_reg;
  assign route = route_reg;
  assign seq_empty = seq_empty_reg;
  assign cal_write = cal_write_reg;
  assign cal_setup = cal_setup_reg;

  // ==========================================================
  // Checks
  chk_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_ok && hit_ctrl |=> ctrl_reg == ($past(req.wdata[15:0]) & `ACSQ_MASK_CTRL))
    else $error("control write not stored");

  chk_err_summary: assert property (@(posedge core_clk) disable iff (rst)
    |(fault & gate) |=> status_err)
    else $error("summary error bit disagrees with flags");

  chk_flag_set: assert property (@(posedge core_clk) disable iff (rst)
    |(fault & gate) |=> |flags_reg)
    else $error("enabled fault did not set a flag");

  chk_count_step: assert property (@(posedge core_clk) disable iff (rst)
    count_on && mclk_tick |=> count_reg == $past(count_reg) + 8'h01)
    else $error("clock counter missed a pulse");

  chk_count_hold: assert property (@(posedge core_clk) disable iff (rst)
    !count_on |=> $stable(count_reg))
    else $error("clock counter moved while off");

  chk_ignore_write: assert property (@(posedge core_clk) disable iff (rst)
    req.wr && hit_ctrl && ignore_on && write_block |=> $stable(ctrl_reg)
      && flags_reg[`ACSQ_BIT_IGNORE])
    else $error("blocked write was taken or not flagged");

  chk_seq_enabled: assert property (@(posedge core_clk) disable iff (rst)
    |ch_en |=> !seq_empty)
    else $error("sequence reported empty with a channel enabled");

  chk_seq_step: assert property (@(posedge core_clk) disable iff (rst)
    op_cont && conv_done && ch_en[active_reg] |=> active_reg == $past(seq_step))
    else $error("sequencer did not step to next enabled channel");

  chk_on_enabled: assert property (@(posedge core_clk) disable iff (rst)
    ##1 |ch_en && $stable(ch_en) |-> ch_en[active_reg])
    else $error("sequencer rests on a disabled channel");

  chk_buf_force: assert property (@(posedge core_clk) disable iff (rst)
    route.gain_select != 3'h0 |-> route.positive_input_buffer_on
      && route.negative_input_buffer_on)
    else $error("buffers off at gain above one");

  chk_cal_write: assert property (@(posedge core_clk) disable iff (rst)
    cal_done && op_cal |=> cal_write && cal_setup == $past(route.setup))
    else $error("calibration result not routed to setup");

  cov_seq_wrap: cover property (@(posedge core_clk) disable iff (rst)
    op_cont && conv_done && seq_step < active_reg);
  cov_ignored: cover property (@(posedge core_clk) disable iff (rst)
    req.wr && ignore_on && write_block);
  cov_cal: cover property (@(posedge core_clk) disable iff (rst) cal_write);
  cov_err: cover property (@(posedge core_clk) disable iff (rst) $rose(status_err));

endmodule
`default_nettype wire

// file: verification/acsq_host.sv
// Host model that issues register accesses to the bank
`timescale 1ns/1ps
`default_nettype none

module acsq_host (
  input wire logic core_clk, // Core clock
  output var acsq_pkg::acsq_req_type req, // Access request
  input wire logic [23:0] rdata, // Read data
  input wire logic rdata_valid // Read strobe
);
  // ==========
  // Access tasks
  // Requests change after a falling edge and span one rising edge
  initial req = '0;

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge core_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    req.wr = 1'b0;
    req.wdata = ~d; // Stale data must not look valid
  endtask

  // Bounded wait for the read strobe
  task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
    int n;
    @(negedge core_clk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge core_clk);
    req.rd = 1'b0;
    ok = 1'b0;
    d = '0;
    for (n = 0; n < 3 && !ok; n++)
    begin
      if (rdata_valid === 1'b1)
      begin
        ok = 1'b1;
        d = rdata;
      end
      else
        @(negedge core_clk);
    end
  endtask
endmodule

`default_nettype wire

// file: verification/adc_config_and_channel_sequencer_tb.sv
// Self-checking bench for the register bank and channel sequencer
`timescale 1ns/1ps
`default_nettype none

module adc_config_and_channel_sequencer_tb;
  logic core_clk;
  logic rst = 1'b1;
  logic write_block = 1'b0;
  logic [23:0] diag_event = '0;
  logic mclk_tick = 1'b0;
  logic conv_done = 1'b0;
  logic cal_done = 1'b0;
  acsq_pkg::acsq_req_type req;
  acsq_pkg::acsq_ctrl_type ctrl;
  acsq_pkg::acsq_route_type route;
  logic [23:0] rdata;
  logic rdata_valid;
  logic status_err;
  logic seq_empty;
  logic cal_write;
  logic [2:0] cal_setup;
  int failures = 0;
  int cmp_count = 0;

  // ==========
  // Clock and instances
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  acsq_regbank i_acsq_regbank (.core_clk(core_clk), .rst(rst), .req(req),
    .write_block(write_block), .diag_event(diag_event), .mclk_tick(mclk_tick),
    .conv_done(conv_done), .cal_done(cal_done), .rdata(rdata),
    .rdata_valid(rdata_valid), .status_err(status_err), .ctrl(ctrl), .route(route),
    .seq_empty(seq_empty), .cal_write(cal_write), .cal_setup(cal_setup));

  acsq_host i_acsq_host (.core_clk(core_clk), .req(req), .rdata(rdata),
    .rdata_valid(rdata_valid));

  // ==========
  // Shared helpers
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A read that never answers ends the run
  task automatic rchk(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic ok;
    i_acsq_host.rd(a, d, ok);
    if (ok !== 1'b1)
    begin
      chk({23'h0, ok}, 24'h1);
      close_out();
    end
    else
      chk(d, exp);
  endtask

  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    i_acsq_host.wr(a, d);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    int a;
    @(negedge core_clk);
    chk(24'(ctrl), 24'h0);
    chk(24'({route.positive_input_select, route.negative_input_select}), 24'h1);
    chk(24'({route.positive_input_buffer_on, route.negative_input_buffer_on}), 24'h3);
    rchk(6'h01, 24'h0);
    rchk(6'h06, 24'h0);
    rchk(6'h07, 24'h000040);
    rchk(6'h08, 24'h0);
    for (a = 9; a <= 24; a++)
      rchk(6'(a), 24'h008001);
    for (a = 25; a <= 32; a++)
      rchk(6'(a), 24'h000860);
    rchk(6'h3f, 24'h0);
    $display("reset test done");
  endtask

  task automatic t_ctrl();
    int m;
    wr(6'h01, 24'hffffff);
    rchk(6'h01, 24'h001fff);
    chk(24'({ctrl.continuous_result_read, ctrl.data_with_status}), 24'h3);
    chk(24'({ctrl.cs_enable, ctrl.ref_enable, ctrl.clock_select}), 24'hf);
    for (m = 0; m < 3; m++)
    begin
      wr(6'h01, 24'(m << 6));
      chk(24'(ctrl.power_mode), 24'(m));
    end
    for (m = 0; m < 9; m++)
    begin
      wr(6'h01, 24'(m << 2));
      chk(24'(ctrl.op_mode), 24'(m));
    end
    wr(6'h06, 24'hffffff);
    rchk(6'h06, 24'h0);
    wr(6'h08, 24'hffffff);
    rchk(6'h08, 24'h0);
    wr(6'h01, 24'h0);
    $display("control test done");
  endtask

  task automatic t_diag();
    wr(6'h07, 24'h000043);
    @(negedge core_clk);
    diag_event = 24'h000005; // Bit 2 stays disabled
    @(negedge core_clk);
    diag_event = 24'h0;
    @(negedge core_clk);
    chk(24'(status_err), 24'h1);
    rchk(6'h06, 24'h000001);
    rchk(6'h06, 24'h0);
    @(negedge core_clk);
    chk(24'(status_err), 24'h0);
    $display("diagnostic test done");
  endtask

  // Blocked write is dropped and raises the write-ignore flag
  task automatic t_ignore();
    wr(6'h07, 24'h000040);
    @(negedge core_clk);
    write_block = 1'b1;
    wr(6'h01, 24'h000003);
    @(negedge core_clk);
    write_block = 1'b0;
    chk(24'(ctrl), 24'h0);
    chk(24'(status_err), 24'h1);
    rchk(6'h06, 24'h000040);
    $display("write ignore test done");
  endtask

  task automatic t_count();
    wr(6'h07, 24'h400000);
    repeat (5) pulse(mclk_tick);
    rchk(6'h08, 24'h5);
    wr(6'h07, 24'h0);
    repeat (2) pulse(mclk_tick);
    rchk(6'h08, 24'h5);
    wr(6'h07, 24'h400000);
    repeat (251) pulse(mclk_tick);
    rchk(6'h08, 24'h0);
    wr(6'h07, 24'h0);
    $display("counter test done");
  endtask

  task automatic step(input logic [3:0] ch);
    pulse(conv_done);
    @(negedge core_clk);
    chk(24'(route.channel), 24'(ch));
  endtask

  task automatic t_seq();
    int a;
    for (a = 10; a <= 24; a++)
      wr(6'(a), 24'h000001);
    wr(6'h0c, 24'h00a0ac); // Channel 3: setup 2, inputs 5 and 12
    wr(6'h0e, 24'h009043); // Channel 5: setup 1, inputs 2 and 3
    wr(6'h1b, 24'h000805); // Gain code 5, buffer bits clear
    wr(6'h1a, 24'h000358); // Gain one, positive buffer only, burnout 1, positive reference buffer, reference 3
    step(4'h3);
    chk(24'({route.setup, route.positive_input_select, route.negative_input_select}),
      24'(13'h08ac));
    chk(24'({route.positive_input_buffer_on, route.negative_input_buffer_on}), 24'h3);
    chk(24'(route.gain_select), 24'h5);
    chk(24'({route.bipolar, route.burnout, route.positive_reference_buffer_on,
      route.negative_reference_buffer_on, route.ref_select}), 24'h40);
    step(4'h5);
    chk(24'({route.positive_input_buffer_on, route.negative_input_buffer_on}), 24'h2);
    chk(24'({route.bipolar, route.burnout, route.positive_reference_buffer_on,
      route.negative_reference_buffer_on, route.ref_select}), 24'h1b);
    step(4'h0);
    wr(6'h01, 24'h000004);
    step(4'h0);
    wr(6'h01, 24'h0);
    wr(6'h09, 24'h000001);
    wr(6'h0e, 24'h001043);
    repeat (2) @(negedge core_clk);
    chk(24'(route.channel), 24'h3);
    step(4'h3);
    chk(24'(seq_empty), 24'h0);
    $display("sequencer test done");
  endtask

  task automatic t_cal();
    wr(6'h01, 24'h000010);
    pulse(cal_done);
    chk(24'({cal_write, cal_setup}), 24'ha);
    wr(6'h01, 24'h000020);
    pulse(cal_done);
    chk(24'({cal_write, cal_setup}), 24'ha);
    wr(6'h01, 24'h0);
    pulse(cal_done);
    chk(24'(cal_write), 24'h0);
    wr(6'h0c, 24'h002000);
    repeat (2) @(negedge core_clk);
    chk(24'(seq_empty), 24'h1);
    $display("calibration test done");
  endtask

  // ==========
  // Main sequence
  initial
  begin
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_ctrl();
    t_diag();
    t_ignore();
    t_count();
    t_seq();
    t_cal();
    close_out();
  end
endmodule

`default_nettype wire
